// ### rtl/oac_defs.vh
/*
 * Constants for the oscillator source and auxiliary PLL control block:
 * APB register offsets, field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the rtl files of this block.
 */
`ifndef OAC_DEFS_VH
`define OAC_DEFS_VH

// Register byte offsets
`define OAC_OFS_CTRL 12'h000
`define OAC_OFS_AUX_CTRL 12'h004
`define OAC_OFS_AUX_DIV 12'h008
`define OAC_OFS_TRIM 12'h00C
`define OAC_OFS_STATUS 12'h010
`define OAC_OFS_CONFIG 12'h014

// Control register fields
`define OAC_CTRL_REQ_BIT 0
`define OAC_CTRL_NEW_LSB 8
`define OAC_CTRL_CUR_LSB 12
`define OAC_CTRL_LOCK_BIT 5

// Auxiliary control fields
`define OAC_AUX_EN_BIT 15
`define OAC_AUX_SRC_BIT 8
`define OAC_AUX_PRE_LSB 0

// Auxiliary divider fields
`define OAC_AUX_FB_LSB 0
`define OAC_AUX_POST1_LSB 8
`define OAC_AUX_POST2_LSB 12

// Source selection codes
`define OAC_SRC_FRC 3'h0
`define OAC_SRC_FRC_PLL 3'h1
`define OAC_SRC_PRI 3'h2
`define OAC_SRC_PRI_PLL 3'h3
`define OAC_SRC_RSVD 3'h4
`define OAC_SRC_LOW_POWER_RC_OSC 3'h5
`define OAC_SRC_BACKUP_FAST_RC_OSC 3'h6
`define OAC_SRC_FRC_DIV 3'h7

// Primary mode codes
`define OAC_PRI_EXT 2'h0
`define OAC_PRI_MED 2'h1
`define OAC_PRI_HIGH 2'h2

// Reset values
`define OAC_RST_AUX_PRE 4'h1
`define OAC_RST_AUX_FB 8'h96
`define OAC_RST_POST 3'h1

// Timing
`define OAC_PCLK_MHZ 20
`define OAC_LOCK_TIME_US 100
`define OAC_LOCK_CYCLES (`OAC_LOCK_TIME_US * `OAC_PCLK_MHZ)
`define OAC_SWITCH_SETTLE 4

`endif

// ### rtl/oac_clk_switch.v
/*
 * Glitch-free switch between two clock selections, modelled as a
 * handshake: the old source stays current until the new one is ready.
 * Assumes source-ready levels are synchronous to pclk.
 */
`timescale 1ns/10ps
`default_nettype none

module oac_clk_switch #(
    parameter SETTLE = 4
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Request
    input wire start,
    input wire [2:0] target,
    input wire target_ready,
    // Result
    output reg [2:0] current,
    output reg busy,
    output reg done
);

reg [3:0] settle_reg;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        current <= 3'h7;
        busy <= 1'b0;
        done <= 1'b0;
        settle_reg <= 4'h0;
    end else begin
        done <= 1'b0;
        if (start && !busy) begin
            busy <= 1'b1;
            settle_reg <= SETTLE[3:0];
        end else if (busy) begin
            if (!target_ready) begin
                settle_reg <= SETTLE[3:0];
            end else if (settle_reg != 4'h0) begin
                settle_reg <= settle_reg - 4'h1;
            end else begin
                current <= target;
                busy <= 1'b0;
                done <= 1'b1;
            end
        end
    end
end

endmodule

`default_nettype wire

// ### rtl/oac_top.v
/*
 * Oscillator source and auxiliary PLL control: APB registers, power-on
 * source decode, clock switch request, lock status, auxiliary PLL
 * enable and frequency arithmetic, instruction clock and low-power RC
 * oscillator policy. Assumes analog sources are represented by ready
 * levels synchronous to pclk and straps stable while presetn is high.
 */
`timescale 1ns/10ps
`default_nettype none
`include "oac_defs.vh"

////////////////////////////////////////////////////////////////////////
module oac_top #(
    parameter LOCK_CYCLES = `OAC_LOCK_CYCLES,
    parameter [2:0] ERASED_SOURCE = `OAC_SRC_FRC_DIV
) (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Configuration straps
    input wire cfg_programmed,
    input wire [2:0] poweron_source_select,
    input wire [1:0] primary_mode_select,
    input wire output_pin_function_select,
    // System status
    input wire sleep_mode,
    input wire failsafe_monitor_en,
    input wire watchdog_en,
    input wire powerup_timer_done,
    input wire pll_locked,
    input wire primary_osc_ready,
    input wire aux_pll_clk_request,
    // Clock control outputs
    output reg [2:0] current_source,
    output reg [1:0] primary_osc_mode,
    output reg instr_clk,
    output reg crystal_output_pin_o,
    output reg crystal_output_pin_oe,
    output reg low_power_rc_osc_en,
    output reg [5:0] fast_rc_trim,
    output reg aux_pll_run,
    output reg aux_pll_from_fast_rc
);

reg [2:0] new_source_select_reg;
reg switch_request_reg;
reg aux_pll_enable_reg;
reg aux_pll_source_select_reg;
reg [3:0] aux_pll_prescaler_reg;
reg [7:0] aux_pll_feedback_divider_reg;
reg [2:0] aux_pll_postscaler_one_reg;
reg [2:0] aux_pll_postscaler_two_reg;
reg [2:0] strap_source_reg;
reg strap_taken_reg;
reg [31:0] lock_count_reg;
reg lock_reg;
reg sys_div_reg;
wire [2:0] sw_current;
wire sw_busy;
wire sw_done;
wire target_ready;
wire crystal_mode;
wire pin_free;
wire wr_en;
wire rd_en;
wire [11:0] aux_vco_ratio;
reg [31:0] rdata_next;

////////////////////////////////////////////////////////////////////////
// Clock switch handshake

assign wr_en = psel && penable && pwrite && pready;
assign rd_en = psel && !penable && !pwrite;
assign crystal_mode = (primary_mode_select == `OAC_PRI_MED) ||
    (primary_mode_select == `OAC_PRI_HIGH);
assign target_ready = ((new_source_select_reg != `OAC_SRC_PRI) &&
    (new_source_select_reg != `OAC_SRC_PRI_PLL)) || primary_osc_ready;

// Done blocks a restart while the finished request is still being cleared
oac_clk_switch #(
    .SETTLE(`OAC_SWITCH_SETTLE)
) u_switch (
    .pclk(pclk),
    .presetn(presetn),
    .start(switch_request_reg && strap_taken_reg && !sw_done),
    .target(new_source_select_reg),
    .target_ready(target_ready),
    .current(sw_current),
    .busy(sw_busy),
    .done(sw_done)
);

////////////////////////////////////////////////////////////////////////
// Registers

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        new_source_select_reg <= `OAC_SRC_FRC_DIV;
        switch_request_reg <= 1'b0;
        aux_pll_enable_reg <= 1'b0;
        aux_pll_source_select_reg <= 1'b0;
        aux_pll_prescaler_reg <= `OAC_RST_AUX_PRE;
        aux_pll_feedback_divider_reg <= `OAC_RST_AUX_FB;
        aux_pll_postscaler_one_reg <= `OAC_RST_POST;
        aux_pll_postscaler_two_reg <= `OAC_RST_POST;
        fast_rc_trim <= 6'h00;
        strap_source_reg <= `OAC_SRC_FRC_DIV;
        strap_taken_reg <= 1'b0;
    end else begin
        // Straps are caught once, after reset release
        if (!strap_taken_reg) begin
            strap_taken_reg <= 1'b1;
            strap_source_reg <= cfg_programmed ? poweron_source_select : ERASED_SOURCE;
            new_source_select_reg <= cfg_programmed ? poweron_source_select : ERASED_SOURCE;
            switch_request_reg <= 1'b1;
        end
        if (sw_done) begin
            switch_request_reg <= 1'b0;
        end
        if (wr_en) begin
            case (paddr)
                `OAC_OFS_CTRL: begin
                    if (!sw_busy) begin
                        new_source_select_reg <= pwdata[`OAC_CTRL_NEW_LSB +: 3];
                    end
                    // A new request wins over a completion in the same cycle
                    if (pwdata[`OAC_CTRL_REQ_BIT]) begin
                        switch_request_reg <= 1'b1;
                    end
                end
                `OAC_OFS_AUX_CTRL: begin
                    aux_pll_enable_reg <= pwdata[`OAC_AUX_EN_BIT];
                    aux_pll_source_select_reg <= pwdata[`OAC_AUX_SRC_BIT];
                    aux_pll_prescaler_reg <= pwdata[`OAC_AUX_PRE_LSB +: 4];
                end
                `OAC_OFS_AUX_DIV: begin
                    aux_pll_feedback_divider_reg <= pwdata[`OAC_AUX_FB_LSB +: 8];
                    aux_pll_postscaler_one_reg <= pwdata[`OAC_AUX_POST1_LSB +: 3];
                    aux_pll_postscaler_two_reg <= pwdata[`OAC_AUX_POST2_LSB +: 3];
                end
                `OAC_OFS_TRIM: begin
                    fast_rc_trim <= pwdata[5:0];
                end
                default: begin
                end
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Lock status: start-up timer restarts whenever PLL is not current

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        lock_count_reg <= 32'h0;
        lock_reg <= 1'b0;
    end else begin
        if (!((sw_current == `OAC_SRC_FRC_PLL) || (sw_current == `OAC_SRC_PRI_PLL))) begin
            lock_count_reg <= 32'h0;
            lock_reg <= 1'b0;
        end else if (pll_locked || (lock_count_reg >= LOCK_CYCLES - 1)) begin
            lock_reg <= 1'b1;
        end else begin
            lock_count_reg <= lock_count_reg + 32'h1;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Clock outputs and oscillator policy

assign pin_free = output_pin_function_select && !crystal_mode;
assign aux_vco_ratio = {4'h0, aux_pll_feedback_divider_reg};

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        current_source <= `OAC_SRC_FRC_DIV;
        primary_osc_mode <= `OAC_PRI_EXT;
        sys_div_reg <= 1'b0;
        instr_clk <= 1'b0;
        crystal_output_pin_o <= 1'b0;
        crystal_output_pin_oe <= 1'b0;
        low_power_rc_osc_en <= 1'b1;
        aux_pll_run <= 1'b0;
        aux_pll_from_fast_rc <= 1'b0;
    end else begin
        // reserved code runs as fast RC
        current_source <= (sw_current == `OAC_SRC_RSVD) ? `OAC_SRC_FRC : sw_current;
        primary_osc_mode <= primary_mode_select;
        sys_div_reg <= ~sys_div_reg;
        instr_clk <= sys_div_reg;
        crystal_output_pin_oe <= pin_free;
        crystal_output_pin_o <= pin_free & sys_div_reg;
        if (sleep_mode) begin
            low_power_rc_osc_en <= 1'b0;
        end else begin
            low_power_rc_osc_en <= failsafe_monitor_en || watchdog_en ||
                (sw_current == `OAC_SRC_LOW_POWER_RC_OSC) || !powerup_timer_done;
        end
        aux_pll_run <= aux_pll_enable_reg && aux_pll_clk_request;
        aux_pll_from_fast_rc <= aux_pll_source_select_reg;
    end
end

////////////////////////////////////////////////////////////////////////
// APB slave: zero wait states, unmapped addresses flag an error

always @* begin
    rdata_next = 32'h0;
    case (paddr)
        `OAC_OFS_CTRL: begin
            rdata_next[`OAC_CTRL_CUR_LSB +: 3] = sw_current;
            rdata_next[`OAC_CTRL_NEW_LSB +: 3] = new_source_select_reg;
            rdata_next[`OAC_CTRL_LOCK_BIT] = lock_reg;
            rdata_next[`OAC_CTRL_REQ_BIT] = switch_request_reg;
        end
        `OAC_OFS_AUX_CTRL: begin
            rdata_next[`OAC_AUX_EN_BIT] = aux_pll_enable_reg;
            rdata_next[`OAC_AUX_SRC_BIT] = aux_pll_source_select_reg;
            rdata_next[`OAC_AUX_PRE_LSB +: 4] = aux_pll_prescaler_reg;
        end
        `OAC_OFS_AUX_DIV: begin
            rdata_next[`OAC_AUX_FB_LSB +: 8] = aux_pll_feedback_divider_reg;
            rdata_next[`OAC_AUX_POST1_LSB +: 3] = aux_pll_postscaler_one_reg;
            rdata_next[`OAC_AUX_POST2_LSB +: 3] = aux_pll_postscaler_two_reg;
        end
        `OAC_OFS_TRIM: begin
            rdata_next[5:0] = fast_rc_trim;
        end
        `OAC_OFS_STATUS: begin
            // ratio terms: VCO = in*fb/pre, out = VCO/(p1*p2)
            rdata_next[11:0] = aux_vco_ratio;
            rdata_next[15:12] = aux_pll_prescaler_reg;
            rdata_next[21:16] = {3'h0, aux_pll_postscaler_one_reg} *
                {3'h0, aux_pll_postscaler_two_reg};
            rdata_next[24] = aux_pll_run;
            rdata_next[25] = low_power_rc_osc_en;
            rdata_next[26] = sw_busy;
        end
        `OAC_OFS_CONFIG: begin
            rdata_next[2:0] = strap_source_reg;
            rdata_next[5:4] = primary_mode_select;
            rdata_next[8] = output_pin_function_select;
        end
        default: begin
            rdata_next = 32'h0;
        end
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= psel && !penable;
        pslverr <= psel && !penable && (paddr > `OAC_OFS_CONFIG || paddr[1:0] != 2'h0);
        if (rd_en) begin
            prdata <= rdata_next;
        end
    end
end

endmodule

`default_nettype wire

// ### dv/oac_checker.sv
/* Port checker for oac_top: APB answer, source decode, instruction clock,
   pin and oscillator policy. Bound from tb; sees top ports only. */
`timescale 1ns/10ps
`default_nettype none
module oac_checker (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    // Straps and status
    input wire [1:0] primary_mode_select,
    input wire output_pin_function_select,
    input wire sleep_mode,
    input wire failsafe_monitor_en,
    input wire watchdog_en,
    input wire powerup_timer_done,
    input wire aux_pll_clk_request,
    // Clock outputs
    input wire [2:0] current_source,
    input wire instr_clk,
    input wire crystal_output_pin_o,
    input wire crystal_output_pin_oe,
    input wire low_power_rc_osc_en,
    input wire aux_pll_run
);
    wire pll_src = current_source == 3'h1 || current_source == 3'h3;
    wire keep = failsafe_monitor_en || watchdog_en || !powerup_timer_done;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence ack_s;
        psel && penable && pready;
    endsequence
    sequence half_s;
        $changed(instr_clk) ##1 $changed(instr_clk);
    endsequence
    ////////////////////////////////////////////////////////////////////
    apb_answer_a: assert property (setup_s |=> ack_s)
        else $error("setup not answered next cycle");
    ack_phase_a: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    // Lock register lags the source by up to two cycles
    lock_src_a: assert property (pready && !pwrite && paddr == 12'h000 && prdata[5]
        |-> pll_src || $past(pll_src) || $past(pll_src, 2))
        else $error("lock set on a non-PLL source");
    src_code_a: assert property (current_source != 3'h4)
        else $error("reserved source code shown");
    erased_start_a: assert property ($rose(presetn) |-> current_source == 3'h7)
        else $error("reset source not fast RC divided");
    instr_half_a: assert property ($changed(instr_clk) |=> half_s)
        else $error("instruction clock not half rate");
    pin_mode_a: assert property (crystal_output_pin_oe |-> output_pin_function_select
        && primary_mode_select != 2'h1 && primary_mode_select != 2'h2)
        else $error("pin driven in crystal mode");
    pin_clock_a: assert property (crystal_output_pin_o == (crystal_output_pin_oe && instr_clk))
        else $error("pin does not carry instruction clock");
    sleep_stop_a: assert property ($past(sleep_mode) |-> !low_power_rc_osc_en)
        else $error("low-power RC on in sleep");
    low_power_rc_osc_keep_a: assert property ($past(!sleep_mode && keep) |-> low_power_rc_osc_en)
        else $error("low-power RC dropped while needed");
    low_power_rc_osc_drop_a: assert property ($past(!sleep_mode && !keep) && current_source != 3'h5
        && $past(current_source) != 3'h5 |-> !low_power_rc_osc_en)
        else $error("low-power RC kept without cause");
    run_req_a: assert property (!$past(aux_pll_clk_request) |-> !aux_pll_run)
        else $error("aux PLL runs without request");
endmodule
`default_nettype wire

// ### dv/tb.sv
/* Testbench for oac_top: APB tasks, read notes checked by a monitor,
   strap, switch, low-power RC and aux PLL scenarios.
   Assumes oac_checker is compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, q;
    wire [31:0] prdata;
    wire pready, pslverr, ic, xo, xoe, lpe, run, ffr;
    logic cfg, pfs, slp, fsm, wdt, ptd, plk, pry, req;
    logic [2:0] pss, p1, p2;
    logic [1:0] pms;
    logic [3:0] pre;
    logic [7:0] fb;
    logic [5:0] t, pp;
    wire [2:0] cur;
    wire [1:0] pom;
    wire [5:0] trim;
    logic [64:0] notes[$];
    logic [64:0] nt;
    integer failures, samples_checked, i;
    oac_top #(.LOCK_CYCLES(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cfg_programmed(cfg), .poweron_source_select(pss),
        .primary_mode_select(pms), .output_pin_function_select(pfs), .sleep_mode(slp),
        .failsafe_monitor_en(fsm), .watchdog_en(wdt), .powerup_timer_done(ptd),
        .pll_locked(plk), .primary_osc_ready(pry), .aux_pll_clk_request(req),
        .current_source(cur), .primary_osc_mode(pom), .instr_clk(ic),
        .crystal_output_pin_o(xo), .crystal_output_pin_oe(xoe), .low_power_rc_osc_en(lpe),
        .fast_rc_trim(trim), .aux_pll_run(run), .aux_pll_from_fast_rc(ffr));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////
    task close_out;
        begin
            $display("checked %0d mismatches %0d", samples_checked, failures);
            if (failures == 0 && samples_checked > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask
    task check(input logic [31:0] s, input logic [31:0] x);
        begin
            samples_checked = samples_checked + 1;
            if (s !== x) begin
                failures = failures + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, s, x);
            end
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer n;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge pclk);
            end
            if (pready !== 1'b1) begin
                failures = failures + 1;
                close_out;
            end
            q = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m, input logic er);
        begin
            notes.push_back({er, m, x});
            apb(1'b0, a, 32'h0);
        end
    endtask
    task poll;
        integer n;
        begin
            n = 0;
            q = 32'h1;
            while (q[0] !== 1'b0 && n < 100) begin
                rd(12'h000, 32'h0, 32'h0, 1'b0);
                n = n + 1;
            end
            if (q[0] !== 1'b0) begin
                failures = failures + 1;
                close_out;
            end
        end
    endtask
    // Straps change only while reset is held
    task rst(input logic [2:0] s, input logic [1:0] m, input logic f, input logic c);
        begin
            presetn <= 1'b0;
            ptd <= 1'b0;
            @(posedge pclk);
            pss <= s;
            pms <= m;
            pfs <= f;
            cfg <= c;
            repeat (16) @(posedge pclk);
            presetn <= 1'b1;
            repeat (2) @(posedge pclk);
        end
    endtask
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            check(prdata & nt[63:32], nt[31:0] & nt[63:32]);
            check(32'(pslverr), 32'(nt[64]));
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {cfg, pss, pms, pfs, slp, fsm, wdt, ptd, plk, req} = '0;
        pry = 1'b1;
        failures = 0;
        samples_checked = 0;
        void'($urandom(32'hDBE9));
        rst(3'h0, 2'h0, 1'b0, 1'b0);
        check(32'(cur), 32'h7);
        rd(12'h004, 32'h1, '1, 1'b0);
        rd(12'h008, 32'h1196, '1, 1'b0);
        rd(12'h018, 32'h0, '1, 1'b1);
        for (i = 0; i < 8; i = i + 1) begin
            rst(i[2:0], i[1:0], i[2], 1'b1);
            poll;
            repeat (2) @(posedge pclk);
            check(32'(cur), 32'((i == 4) ? 3'h0 : i[2:0]));
            check(32'(pom), 32'(i[1:0]));
            check(32'(xoe), 32'(i[2] && i[1:0] != 2'h1 && i[1:0] != 2'h2));
        end
        ptd <= 1'b1;
        // codes in rising order never step PLL to PLL
        for (i = 0; i < 8; i = i + 1) begin
            pry <= (i != 2);
            apb(1'b1, 12'h000, {21'h0, i[2:0], 8'h01});
            if (i == 2) begin
                apb(1'b1, 12'h000, 32'h0601);
                repeat (20) @(posedge pclk);
                check(32'(cur), 32'h1);
                pry <= 1'b1;
            end
            poll;
            repeat (12) @(posedge pclk); // lock settles
            rd(12'h000, {17'h0, i[2:0], 1'b0, i[2:0], 2'h0,
                i == 1 || i == 3, 5'h0}, '1, 1'b0);
            check(32'(lpe), 32'(i == 5));
        end
        for (i = 0; i < 4; i = i + 1) begin
            fsm <= (i == 0);
            wdt <= (i == 1 || i == 2);
            slp <= (i == 2);
            repeat (3) @(posedge pclk);
            check(32'(lpe), 32'(i < 2));
        end
        // input taken as 8 MHz times prescaler, VCO 8 MHz times feedback
        for (i = 0; i < 4; i = i + 1) begin
            pre = i[1] ? 4'h1 : 4'h1 + $urandom_range(7);
            fb = 8'h32 + $urandom_range(150);
            p1 = 3'h1 + $urandom_range(6);
            p2 = 3'h1 + $urandom_range(6);
            pp = p1 * p2;
            t = $urandom;
            req <= (i != 1);
            apb(1'b1, 12'h004, {16'h0, i[0], 6'h0, i[1], 4'h0, pre});
            apb(1'b1, 12'h008, {17'h0, p2, 1'b0, p1, fb});
            apb(1'b1, 12'h00C, {26'h0, t});
            repeat (3) @(posedge pclk);
            rd(12'h010, {7'h0, i == 3, 2'h0, pp, pre, 4'h0, fb}, '1, 1'b0);
            check(32'(run), 32'(i == 3));
            check(32'(ffr), 32'(i[1]));
            check(32'(trim), 32'(t));
        end
        repeat (4) @(posedge pclk);
        close_out;
    end
endmodule
bind oac_top oac_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .primary_mode_select(primary_mode_select),
    .output_pin_function_select(output_pin_function_select), .sleep_mode(sleep_mode),
    .failsafe_monitor_en(failsafe_monitor_en), .watchdog_en(watchdog_en),
    .powerup_timer_done(powerup_timer_done), .aux_pll_clk_request(aux_pll_clk_request),
    .current_source(current_source), .instr_clk(instr_clk),
    .crystal_output_pin_o(crystal_output_pin_o), .crystal_output_pin_oe(crystal_output_pin_oe),
    .low_power_rc_osc_en(low_power_rc_osc_en), .aux_pll_run(aux_pll_run));
`default_nettype wire
